// [design/gbi_pkg.sv]
package gbi_pkg;

	localparam int AD_W = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 160;
	localparam int PHASE_W = 5;
	// One word per link period at 1X, one per strobe half at 4X/8X
	localparam logic [PHASE_W-1:0] SLOT_1X_CYC =
		PHASE_W'(LINK_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [PHASE_W-1:0] SLOT_FAST_CYC =
		PHASE_W'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	// More toggles than this flips the word
	localparam int TOGGLE_LIMIT = AD_W / 2;
	localparam logic [1:0] STB_FIRST = 2'h1;
	localparam logic [1:0] STB_SECOND = 2'h2;
	localparam logic [1:0] STB_NONE = 2'h0;
	localparam int SYNC_W = 2;

	typedef enum logic [1:0] {
		RATE_1X,
		RATE_4X,
		RATE_8X
	} gbi_rate_t;

	typedef enum logic {
		TX_IDLE,
		TX_SLOT
	} gbi_tx_st_t;

	function automatic logic [PHASE_W-1:0] slot_len(input gbi_rate_t r);
		slot_len = (r == RATE_4X || r == RATE_8X) ? SLOT_FAST_CYC
			: SLOT_1X_CYC;
	endfunction

	function automatic logic is_fast(input gbi_rate_t r);
		is_fast = (r == RATE_4X || r == RATE_8X);
	endfunction

endpackage

// [design/gbi_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface gbi_link_if;
	logic [15:0] dev_ad;
	logic        dev_flag;
	logic        dev_stb_first;
	logic        dev_stb_second;
	logic        dev_oe;
	logic [15:0] acc_ad;
	logic        acc_flag;
	logic        acc_stb_first;
	logic        acc_stb_second;
	logic        acc_oe;
	logic [15:0] graphics_addr_data_low_half;
	logic        low_half_inversion_flag;
	logic        upper_lane_strobe_first;
	logic        upper_lane_strobe_second;

	// Undriven lines settle low, so a released strobe never shows a rise
	assign graphics_addr_data_low_half = dev_oe ? dev_ad
		: (acc_oe ? acc_ad : 16'h0000);
	assign low_half_inversion_flag = dev_oe ? dev_flag
		: (acc_oe & acc_flag);
	assign upper_lane_strobe_first = dev_oe ? dev_stb_first
		: (acc_oe & acc_stb_first);
	assign upper_lane_strobe_second = dev_oe ? dev_stb_second
		: (acc_oe & acc_stb_second);

	modport dev (
		output dev_ad, dev_flag, dev_stb_first, dev_stb_second, dev_oe,
		input  graphics_addr_data_low_half, low_half_inversion_flag,
		input  upper_lane_strobe_first, upper_lane_strobe_second
	);
	modport acc (
		output acc_ad, acc_flag, acc_stb_first, acc_stb_second, acc_oe,
		input  graphics_addr_data_low_half, low_half_inversion_flag,
		input  upper_lane_strobe_first, upper_lane_strobe_second
	);
endinterface
`default_nettype wire

// [design/gbi_dbi_codec.sv]
`timescale 1ns/1ps
`default_nettype none
module gbi_dbi_codec (
	input  wire logic        enc_en,
	input  wire logic [15:0] prev_wire,
	input  wire logic [15:0] tx_word,
	output logic      [15:0] enc_word,
	output logic             enc_flag,
	input  wire logic        dec_en,
	input  wire logic [15:0] rx_word,
	input  wire logic        rx_flag,
	output logic      [15:0] dec_word
);
	function automatic int toggles(input logic [15:0] d);
		toggles = 0;
		for (int i = 0; i < gbi_pkg::AD_W; i++) begin
			toggles += int'(d[i]);
		end
	endfunction

	always_comb begin
		enc_flag = enc_en
			&& (toggles(tx_word ^ prev_wire) > gbi_pkg::TOGGLE_LIMIT);
		enc_word = enc_flag ? ~tx_word : tx_word;
		dec_word = (dec_en && rx_flag) ? ~rx_word : rx_word;
	end
endmodule // gbi_dbi_codec
`default_nettype wire

// [design/gbi_hub_end.sv]
// Operation
// - Flag 1 means receiver inverts all sixteen
// - Inversion exists only in 3.0 signalling
// - At 4X never invert sent data
// - At 4X still decode inverted received data
// - At 8X invert and decode both ways
// - Flag travels with the same strobe pair
// - Reset acts asynchronously on all logic
// - Port pins released while reset asserted
// - No bus lock on this port
// - PCI-style cycles follow revision 2.1 behaviour
// - Port logic runs from the port clock
// - Power good follows stable power and clock
// - Lines run at 1X, 4X or 8X
`timescale 1ns/1ps
`default_nettype none
module gbi_hub_end (
	input  wire logic              mclk,
	input  wire logic              rstn,
	gbi_link_if.dev                link,
	input  wire logic              power_good_input,
	input  wire logic              mode_3p0,
	input  wire gbi_pkg::gbi_rate_t rate,
	input  wire logic              tx_valid,
	input  wire logic [15:0]       tx_data,
	output logic                   tx_ready,
	output logic                   rx_valid,
	output logic      [15:0]       rx_data,
	output logic                   power_good_seen
);
	// Synchronisers, send slot and receive result share one register
	typedef struct packed {
		logic [15:0]         ad_s1;
		logic [15:0]         ad_s2;
		logic                flag_s1;
		logic                flag_s2;
		logic [1:0]          stb_s1;
		logic [1:0]          stb_s2;
		logic [1:0]          stb_s3;
		logic [gbi_pkg::SYNC_W-1:0] pg_s;
		gbi_pkg::gbi_tx_st_t st;
		logic [gbi_pkg::PHASE_W-1:0] phase;
		logic                odd;
		logic [15:0]         ad_o;
		logic                flag_o;
		logic [1:0]          stb_o;
		logic                oe;
		logic [15:0]         prev;
		logic                tx_ready;
		logic                rx_valid;
		logic [15:0]         rx_data;
	} gbi_hub_state_t;

	gbi_hub_state_t q;
	gbi_hub_state_t next_q;

	// Codec hookup and rate timing
	logic        enc_en;
	logic        dec_en;
	logic [15:0] enc_word;
	logic        enc_flag;
	logic [15:0] dec_word;
	logic        fast;
	logic [gbi_pkg::PHASE_W-1:0] slot_last;
	logic [gbi_pkg::PHASE_W-1:0] slot_mid;
	logic        rx_edge;

	// Slot and handshake decodes
	logic        take;
	logic        pg_ok;
	logic        at_mid;
	logic        at_last;

	// Rising edge of either synchronised strobe
	function automatic logic strobe_rise(input logic [1:0] stb_cur,
		input logic [1:0] stb_old);
		strobe_rise = |(stb_cur & ~stb_old);
	endfunction

	// Fast rates alternate lanes so each strobe runs at half the word rate
	function automatic logic [1:0] lane_strobe(input logic fast_rate,
		input logic odd_word);
		if (fast_rate && odd_word) begin
			lane_strobe = gbi_pkg::STB_SECOND;
		end else begin
			lane_strobe = gbi_pkg::STB_FIRST;
		end
	endfunction

	// Sending is never inverted at 4X; only 8X may flip the word
	assign enc_en = mode_3p0
		&& (rate == gbi_pkg::RATE_8X);
	// Receive side honours the flag at every rate of 3.0 signalling
	assign dec_en = mode_3p0;

	// Rate code 3 is not a real rate and is timed as 1X
	assign fast = gbi_pkg::is_fast(rate);
	assign slot_last = gbi_pkg::slot_len(rate) - 1'b1;
	assign slot_mid = gbi_pkg::slot_len(rate) >> 1;
	// Own strobes echo back through the pins; ignore them while driving
	assign rx_edge = !q.oe && strobe_rise(q.stb_s2, q.stb_s3);

	// Synchronised power good gates every send
	assign pg_ok = q.pg_s[1];
	assign take = tx_valid && q.tx_ready;
	assign at_mid = (q.phase == slot_mid);
	assign at_last = (q.phase == slot_last);

	gbi_dbi_codec u_codec (
		.enc_en    (enc_en),
		.prev_wire (q.prev),
		.tx_word   (tx_data),
		.enc_word  (enc_word),
		.enc_flag  (enc_flag),
		.dec_en    (dec_en),
		.rx_word   (q.ad_s2),
		.rx_flag   (q.flag_s2),
		.dec_word  (dec_word)
	);

	always_comb begin
		next_q = q;
		// Every pin input passes two flops before any logic looks at it
		next_q.ad_s1 = link.graphics_addr_data_low_half;
		next_q.ad_s2 = q.ad_s1;
		next_q.flag_s1 = link.low_half_inversion_flag;
		next_q.flag_s2 = q.flag_s1;
		// Three strobe stages: two to synchronise, one to find the edge
		next_q.stb_s1 = {link.upper_lane_strobe_second,
			link.upper_lane_strobe_first};
		next_q.stb_s2 = q.stb_s1;
		next_q.stb_s3 = q.stb_s2;
		next_q.pg_s = {q.pg_s[0], power_good_input};

		// Data and flag were synchronised with the strobes, so the word
		// seen at the strobe rise is the one that strobe launched
		next_q.rx_valid = 1'b0;
		if (rx_edge) begin
			next_q.rx_valid = 1'b1;
			next_q.rx_data = dec_word;
		end

		unique case (q.st)
		gbi_pkg::TX_IDLE: begin
			next_q.stb_o = gbi_pkg::STB_NONE;
			// Sender holds nothing between words, so no locked sequence
			next_q.oe = 1'b0;
			// No word is taken until power good has been synchronised
			next_q.tx_ready = pg_ok;
			if (take) begin
				// Word and flag load on one edge and stand until the next take
				next_q.st = gbi_pkg::TX_SLOT;
				next_q.phase = '0;
				next_q.oe = 1'b1;
				next_q.tx_ready = 1'b0;
				next_q.ad_o = enc_word;
				// Flag is held low unless 8X chose to invert
				next_q.flag_o = enc_flag;
				next_q.prev = enc_word;
			end
		end
		gbi_pkg::TX_SLOT: begin
			next_q.phase = q.phase + 1'b1;
			if (at_mid) begin
				// 1X uses the first strobe only, like a plain clocked cycle
				next_q.stb_o = lane_strobe(fast, q.odd);
			end
			if (at_last) begin
				next_q.stb_o = gbi_pkg::STB_NONE;
				next_q.odd = fast && !q.odd;
				next_q.st = gbi_pkg::TX_IDLE;
				next_q.tx_ready = pg_ok;
			end
		end
		endcase

		// Losing power good ends any word in flight at once; a word cut before
		// its slot midpoint never raises its strobe, so the far end receives nothing
		if (!pg_ok) begin
			next_q.st = gbi_pkg::TX_IDLE;
			next_q.oe = 1'b0;
			next_q.tx_ready = 1'b0;
			next_q.stb_o = gbi_pkg::STB_NONE;
		end
	end

	// All port state lives on the port clock and clears without an edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Pins and user outputs come straight from the state register
	assign link.dev_ad = q.ad_o;
	assign link.dev_flag = q.flag_o;
	assign link.dev_stb_first = q.stb_o[0];
	assign link.dev_stb_second = q.stb_o[1];
	assign link.dev_oe = q.oe;
	assign tx_ready = q.tx_ready;
	assign rx_valid = q.rx_valid;
	assign rx_data = q.rx_data;
	assign power_good_seen = q.pg_s[1];

endmodule // gbi_hub_end
`default_nettype wire

// [design/gbi_gfx_end.sv]
`timescale 1ns/1ps
`default_nettype none
module gbi_gfx_end (
	input  wire logic               mclk,
	input  wire logic               rstn,
	gbi_link_if.acc                 link,
	input  wire logic               mode_3p0,
	input  wire gbi_pkg::gbi_rate_t rate,
	input  wire logic               tx_valid,
	input  wire logic [15:0]        tx_data,
	output logic                    tx_ready,
	output logic                    rx_valid,
	output logic      [15:0]        rx_data
);
	typedef struct packed {
		logic [15:0]         ad_s1;
		logic [15:0]         ad_s2;
		logic                flag_s1;
		logic                flag_s2;
		logic [1:0]          stb_s1;
		logic [1:0]          stb_s2;
		logic [1:0]          stb_s3;
		gbi_pkg::gbi_tx_st_t st;
		logic [gbi_pkg::PHASE_W-1:0] phase;
		logic                odd;
		logic [15:0]         ad_o;
		logic                flag_o;
		logic [1:0]          stb_o;
		logic                oe;
		logic [15:0]         prev;
		logic                tx_ready;
		logic                rx_valid;
		logic [15:0]         rx_data;
	} gbi_gfx_state_t;

	gbi_gfx_state_t q;
	gbi_gfx_state_t next_q;

	logic [15:0] enc_word;
	logic        enc_flag;
	logic [15:0] dec_word;
	logic        fast;
	logic [gbi_pkg::PHASE_W-1:0] slot_last;
	logic [gbi_pkg::PHASE_W-1:0] slot_mid;

	assign fast = gbi_pkg::is_fast(rate);
	assign slot_last = gbi_pkg::slot_len(rate) - 1'b1;
	assign slot_mid = gbi_pkg::slot_len(rate) >> 1;

	// This end may flip at 4X too; the hub decodes at both fast rates
	gbi_dbi_codec u_codec (
		.enc_en    (mode_3p0 && fast),
		.prev_wire (q.prev),
		.tx_word   (tx_data),
		.enc_word  (enc_word),
		.enc_flag  (enc_flag),
		.dec_en    (mode_3p0),
		.rx_word   (q.ad_s2),
		.rx_flag   (q.flag_s2),
		.dec_word  (dec_word)
	);

	always_comb begin
		next_q = q;
		next_q.ad_s1 = link.graphics_addr_data_low_half;
		next_q.ad_s2 = q.ad_s1;
		next_q.flag_s1 = link.low_half_inversion_flag;
		next_q.flag_s2 = q.flag_s1;
		next_q.stb_s1 = {link.upper_lane_strobe_second,
			link.upper_lane_strobe_first};
		next_q.stb_s2 = q.stb_s1;
		next_q.stb_s3 = q.stb_s2;
		next_q.rx_valid = 1'b0;
		if (!q.oe && (|(q.stb_s2 & ~q.stb_s3))) begin
			next_q.rx_valid = 1'b1;
			next_q.rx_data = dec_word;
		end
		unique case (q.st)
		gbi_pkg::TX_IDLE: begin
			next_q.stb_o = gbi_pkg::STB_NONE;
			next_q.oe = 1'b0;
			next_q.tx_ready = 1'b1;
			if (tx_valid && q.tx_ready) begin
				next_q.st = gbi_pkg::TX_SLOT;
				next_q.phase = '0;
				next_q.oe = 1'b1;
				next_q.tx_ready = 1'b0;
				next_q.ad_o = enc_word;
				next_q.flag_o = enc_flag;
				next_q.prev = enc_word;
			end
		end
		gbi_pkg::TX_SLOT: begin
			next_q.phase = q.phase + 1'b1;
			if (q.phase == slot_mid) begin
				next_q.stb_o = (fast && q.odd) ? gbi_pkg::STB_SECOND
					: gbi_pkg::STB_FIRST;
			end
			if (q.phase == slot_last) begin
				next_q.stb_o = gbi_pkg::STB_NONE;
				next_q.odd = fast && !q.odd;
				next_q.st = gbi_pkg::TX_IDLE;
				next_q.tx_ready = 1'b1;
			end
		end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign link.acc_ad = q.ad_o;
	assign link.acc_flag = q.flag_o;
	assign link.acc_stb_first = q.stb_o[0];
	assign link.acc_stb_second = q.stb_o[1];
	assign link.acc_oe = q.oe;
	assign tx_ready = q.tx_ready;
	assign rx_valid = q.rx_valid;
	assign rx_data = q.rx_data;

endmodule // gbi_gfx_end
`default_nettype wire

// [testbench/gbi_link_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module gbi_link_checker (
	input wire logic               mclk,
	input wire logic               rstn,
	input wire logic               mode_3p0,
	input wire gbi_pkg::gbi_rate_t rate,
	input wire logic               dev_oe,
	input wire logic               acc_oe,
	input wire logic               dev_flag,
	input wire logic               power_good_seen,
	input wire logic [15:0]        graphics_addr_data_low_half,
	input wire logic               low_half_inversion_flag,
	input wire logic               upper_lane_strobe_first,
	input wire logic               upper_lane_strobe_second
);
	wire logic stb = upper_lane_strobe_first | upper_lane_strobe_second;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_hub_4x_plain:
	assert property (dev_oe && rate == gbi_pkg::RATE_4X |-> !dev_flag)
		else $error("hub flag high at 4X");
	a_legacy_flag_low:
	assert property (!mode_3p0 && stb |-> !low_half_inversion_flag)
		else $error("flag high in 2.0 mode");
	a_slow_flag_low:
	assert property (rate == gbi_pkg::RATE_1X && stb |-> !low_half_inversion_flag)
		else $error("flag high at 1X");
	a_flag_rides_strobe:
	assert property ($rose(stb) |-> $stable(low_half_inversion_flag)
		&& $stable(graphics_addr_data_low_half) ##1
		$stable(low_half_inversion_flag) && $stable(graphics_addr_data_low_half))
		else $error("lines moved at strobe");
	a_strobe_exclusive:
	assert property (!(upper_lane_strobe_first && upper_lane_strobe_second))
		else $error("both strobes high");
	a_single_driver:
	assert property (!(dev_oe && acc_oe))
		else $error("both ends drive");
	a_reset_released:
	assert property ($rose(rstn) |-> !$past(dev_oe) && !$past(acc_oe))
		else $error("pins driven in reset");
	a_hub_slot_hold:
	assert property ($rose(dev_oe) |-> (dev_oe || !power_good_seen) [*8])
		else $error("hub slot cut short");
	a_pg_loss_release:
	assert property (!power_good_seen |=> !dev_oe)
		else $error("hub drives without power good");
	a_gfx_slot_hold:
	assert property ($rose(acc_oe) |-> acc_oe [*8])
		else $error("gfx slot cut short");
endmodule // gbi_link_checker
`default_nettype wire

// [testbench/graphics_port_bus_inversion_test.sv]
`timescale 1ns/1ps
`default_nettype none
module graphics_port_bus_inversion_test;
	logic               mclk = 1'b0;
	logic               rstn = 1'b0;
	logic               power_good_input = 1'b0;
	logic               mode_3p0 = 1'b1;
	gbi_pkg::gbi_rate_t rate = gbi_pkg::RATE_8X;
	logic               h_valid = 1'b0;
	logic               g_valid = 1'b0;
	logic        [15:0] h_data = 16'h0000;
	logic        [15:0] g_data = 16'h0000;
	logic               h_ready, g_ready, h_rxv, g_rxv, pg_seen, stb;
	logic               stb_d = 1'b0;
	logic        [15:0] h_rx, g_rx;
	logic        [15:0] prev [2];
	logic        [16:0] exp_w, exp_r;
	logic        [16:0] q_wire [$];
	logic        [16:0] q_rx [$];
	int                 err_count = 0;
	int                 checks = 0;

	gbi_link_if link ();
	gbi_hub_end u_gbi_hub_end (.mclk(mclk), .rstn(rstn), .link(link),
		.power_good_input(power_good_input), .mode_3p0(mode_3p0),
		.rate(rate), .tx_valid(h_valid), .tx_data(h_data),
		.tx_ready(h_ready), .rx_valid(h_rxv), .rx_data(h_rx),
		.power_good_seen(pg_seen));
	gbi_gfx_end u_gbi_gfx_end (.mclk(mclk), .rstn(rstn), .link(link),
		.mode_3p0(mode_3p0), .rate(rate), .tx_valid(g_valid),
		.tx_data(g_data), .tx_ready(g_ready), .rx_valid(g_rxv),
		.rx_data(g_rx));
	gbi_link_checker u_gbi_link_checker (.mclk(mclk), .rstn(rstn),
		.mode_3p0(mode_3p0), .rate(rate), .dev_oe(link.dev_oe),
		.acc_oe(link.acc_oe), .dev_flag(link.dev_flag),
		.power_good_seen(pg_seen),
		.graphics_addr_data_low_half(link.graphics_addr_data_low_half),
		.low_half_inversion_flag(link.low_half_inversion_flag),
		.upper_lane_strobe_first(link.upper_lane_strobe_first),
		.upper_lane_strobe_second(link.upper_lane_strobe_second));

	wire logic [16:0] wire_seen = {link.low_half_inversion_flag,
		link.graphics_addr_data_low_half};
	wire logic [16:0] rx_seen = {1'b0, g_rxv === 1'b1 ? g_rx : h_rx};

	always #(gbi_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;

	task automatic check(input string name, input logic [16:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Expected wire word follows the sender's own last wire word
	task automatic send(input logic hub, input logic [15:0] d);
		logic inv;
		inv = mode_3p0 && rate != gbi_pkg::RATE_1X
			&& (!hub || rate == gbi_pkg::RATE_8X)
			&& $countones(d ^ prev[hub]) > gbi_pkg::TOGGLE_LIMIT;
		prev[hub] = inv ? ~d : d;
		q_wire.push_back({inv, prev[hub]});
		q_rx.push_back({1'b0, d});
		if (hub) begin
			h_valid = 1'b1;
			h_data = d;
		end else begin
			g_valid = 1'b1;
			g_data = d;
		end
		while ((hub ? h_ready : g_ready) !== 1'b1)
			@(negedge mclk);
		@(negedge mclk);
	endtask

	task automatic idle;
		h_valid = 1'b0;
		g_valid = 1'b0;
		repeat (40) @(negedge mclk);
	endtask

	always @(negedge mclk) begin
		stb = link.upper_lane_strobe_first | link.upper_lane_strobe_second;
		if (stb && !stb_d) begin
			exp_w = q_wire.size() > 0 ? q_wire.pop_front() : 'x;
			check("wire", wire_seen, exp_w);
		end
		if (g_rxv === 1'b1 || h_rxv === 1'b1) begin
			exp_r = q_rx.size() > 0 ? q_rx.pop_front() : 'x;
			check("rx_data", rx_seen, exp_r);
		end
		stb_d = stb;
	end

	initial begin
		#200000;
		err_count++;
		results();
	end

	initial begin
		prev[0] = 16'h0000;
		prev[1] = 16'h0000;
		void'($urandom(32'hAA748FD0));
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		repeat (10) @(negedge mclk);
		check("tx_ready", {16'h0000, h_ready}, 17'h00000);
		check("pg_seen", {16'h0000, pg_seen}, 17'h00000);
		power_good_input = 1'b1;
		// Exactly eight toggles stay plain, nine flip the word
		for (int e = 0; e < 2; e++) begin
			send(e[0], 16'h00FF);
			send(e[0], 16'h0100);
			idle();
		end
		for (int m = 0; m < 2; m++)
			for (int r = 0; r < 3; r++)
				for (int e = 0; e < 2; e++) begin
					mode_3p0 = m[0];
					rate = gbi_pkg::gbi_rate_t'(r);
					repeat (6) send(e[0], 16'($urandom));
					idle();
				end
		check("pg_seen", {16'h0000, pg_seen}, 17'h00001);
		// Power good lost in mid word: the hub lets go before its strobe
		h_valid = 1'b1;
		while (link.dev_oe !== 1'b1)
			@(negedge mclk);
		power_good_input = 1'b0;
		h_valid = 1'b0;
		repeat (4) @(negedge mclk);
		check("abort", {14'h0, pg_seen, h_ready, link.dev_oe}, 17'h0);
		repeat (8) @(negedge mclk);
		power_good_input = 1'b1;
		h_valid = 1'b1;
		while (link.dev_oe !== 1'b1)
			@(negedge mclk);
		rstn = 1'b0;
		#1 check("oe", {15'h0, link.dev_oe, link.acc_oe}, 17'h0);
		h_valid = 1'b0;
		q_wire.delete();
		q_rx.delete();
		prev[1] = 16'h0000;
		prev[0] = 16'h0000;
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) send(1'b1, 16'($urandom));
		idle();
		check("queues", 17'(q_wire.size() + q_rx.size()), 17'h00000);
		results();
	end
endmodule // graphics_port_bus_inversion_test
`default_nettype wire
